/* pkg/srpp_pkg.sv */
/*
 * srpp_pkg: register map, field positions, reset values and frame
 * constants for the serial receive path with parity.
 * Assumes: a 32-bit APB bus with word-aligned registers.
 */
`default_nettype none
package srpp_pkg;
    // =========================================================
    // register byte addresses
    localparam logic [7:0] SRPP_STATUS_REG_A  = 8'h00;
    localparam logic [7:0] SRPP_CONTROL_REG_B = 8'h04;
    localparam logic [7:0] SRPP_CONTROL_REG_C = 8'h08;
    localparam logic [7:0] SRPP_DATA_BUFFER   = 8'h0c;
    // =========================================================
    // status_reg_a fields
    localparam int SRPP_A_RXC  = 7;
    localparam int SRPP_A_TXE  = 5;
    localparam int SRPP_A_FE   = 4;
    localparam int SRPP_A_DOR  = 3;
    localparam int SRPP_A_UPE  = 2;
    // =========================================================
    // control_reg_b fields
    localparam int SRPP_B_RXCIE = 7;
    localparam int SRPP_B_RXEN  = 4;
    localparam int SRPP_B_TXEN  = 3;
    localparam int SRPP_B_CSZ2  = 2;
    localparam int SRPP_B_RXB8  = 1;
    localparam int SRPP_B_TXB8  = 0;
    localparam logic [7:0] SRPP_B_WMASK = 8'h9d;
    // =========================================================
    // control_reg_c fields
    localparam int SRPP_C_SYNC  = 6;
    localparam int SRPP_C_PEN   = 5;
    localparam int SRPP_C_PODD  = 4;
    localparam int SRPP_C_STOP2 = 3;
    localparam int SRPP_C_CSZ1  = 2;
    localparam int SRPP_C_CSZ0  = 1;
    localparam logic [7:0] SRPP_C_WMASK = 8'h7e;
    // =========================================================
    // reset values
    localparam logic [7:0] SRPP_B_RESET = 8'h00;
    localparam logic [7:0] SRPP_C_RESET = 8'h06;
    // =========================================================
    // frame constants
    localparam logic [2:0] SRPP_CSZ_NINE = 3'h7;
    localparam logic [3:0] SRPP_BITS_MAX = 4'h9;
    localparam logic [3:0] SRPP_BITS_MIN = 4'h5;
    localparam logic [1:0] SRPP_BUF_DEPTH = 2'h2;
    localparam int SRPP_TXF_W = 13;
endpackage
`default_nettype wire

/* logic/srpp_serial_rx.sv */
/*
 * srpp_serial_rx: receive path, two-entry buffer, error flags, parity,
 * transmit parity insertion and deferred transmitter disable.
 * Assumes: pins and bit strobe synchronous to clk_sys; no baud generator.
 */
// Design decisions made here: the placing of the registers and register access over APB.
// Function
// - enabled parity bit sent after last data bit
// - transmitter disable waits until all data sent
// - disabled transmitter releases the output pin
// - receiver enable takes the input pin
// - synchronous mode uses the external clock
// - start bit opens a frame; bits shifted to first stop
// - only the first stop bit is checked
// - first stop bit moves the frame to the buffer
// - unused upper data bits read zero
// - ninth bit and errors kept per entry; read advances
// - complete flag shows unread data; disable flushes
// - receive complete request is a level
// - writes to error flags have no effect
// - error flags raise no request
// - frame error shows low first stop bit
// - overrun: buffer full, frame waiting, new start
// - overrun clears when a frame enters the buffer
// - parity of data bits checked and stored per frame
// - parity error reads zero when checking is off
`timescale 1ns/100ps
`default_nettype none
module srpp_serial_rx
    import srpp_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        bitTick,
    input  wire logic        serialInPin,
    input  wire logic        externalTransferClockPin,
    output logic             serialOutPin,
    output logic             serialOutOe,
    output logic             rxPinOverride,
    input  wire logic        globalIrqEnable,
    output logic             rxCompleteIrq
);
    typedef enum logic [1:0] {
        SRPP_RX_IDLE = 2'b00,
        SRPP_RX_DATA = 2'b01,
        SRPP_RX_PAR  = 2'b11,
        SRPP_RX_STOP = 2'b10
    } srpp_rx_t;

    // =========================================================
    // helpers
    function automatic logic [3:0] charBits(input logic [2:0] csz);
        if (csz == SRPP_CSZ_NINE) begin
            charBits = SRPP_BITS_MAX;
        end else if (csz[2]) begin
            charBits = 4'h8;
        end else begin
            charBits = SRPP_BITS_MIN + {2'b00, csz[1:0]};
        end
    endfunction

    function automatic logic [8:0] bitMask(input logic [3:0] n);
        bitMask = 9'((10'h1 << n) - 10'h1);
    endfunction

    // =========================================================
    // control registers and decode
    logic [7:0]  controlRegB;
    logic [7:0]  controlRegC;
    logic        apbAccess;
    logic        apbSetup;
    logic        mapped;
    logic        rxEnable;
    logic        txEnableBit;
    logic        parityEnableBit;
    logic        parityOddSelect;
    logic        syncMode;
    logic [3:0]  nBits;
    logic [8:0]  dataMask;

    assign rxEnable        = controlRegB[SRPP_B_RXEN];
    assign txEnableBit     = controlRegB[SRPP_B_TXEN];
    assign parityEnableBit = controlRegC[SRPP_C_PEN];
    assign parityOddSelect = controlRegC[SRPP_C_PODD];
    assign syncMode        = controlRegC[SRPP_C_SYNC];
    assign nBits    = charBits({controlRegB[SRPP_B_CSZ2], controlRegC[SRPP_C_CSZ1],
                                controlRegC[SRPP_C_CSZ0]});
    assign dataMask = bitMask(nBits);
    assign mapped   = (paddr == SRPP_STATUS_REG_A) || (paddr == SRPP_CONTROL_REG_B) ||
                      (paddr == SRPP_CONTROL_REG_C) || (paddr == SRPP_DATA_BUFFER);
    assign apbSetup  = ce && psel && !penable;
    assign apbAccess = ce && psel && penable;
    assign pready    = ce;
    assign pslverr   = psel && penable && !mapped;

    logic writeB;
    logic writeC;
    logic writeData;
    logic readData;
    assign writeB    = apbAccess && pwrite && (paddr == SRPP_CONTROL_REG_B);
    assign writeC    = apbAccess && pwrite && (paddr == SRPP_CONTROL_REG_C);
    assign writeData = apbAccess && pwrite && (paddr == SRPP_DATA_BUFFER);
    assign readData  = apbAccess && !pwrite && (paddr == SRPP_DATA_BUFFER);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            controlRegB <= SRPP_B_RESET;
            controlRegC <= SRPP_C_RESET;
        end else if (ce) begin
            if (writeB) begin
                controlRegB <= pwdata[7:0] & SRPP_B_WMASK;
            end
            if (writeC) begin
                controlRegC <= pwdata[7:0] & SRPP_C_WMASK;
            end
        end
    end

    // =========================================================
    // bit sampling strobe
    logic xckPrev;
    logic sampleEn;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            xckPrev <= 1'b0;
        end else if (ce) begin
            xckPrev <= externalTransferClockPin;
        end
    end
    assign sampleEn = syncMode ? (externalTransferClockPin && !xckPrev) : bitTick;

    // =========================================================
    // receive buffer, two entries
    logic [8:0] bufData [2];
    logic       bufFe   [2];
    logic       bufPe   [2];
    logic       bufDor  [2];
    logic       rdPtr;
    logic [1:0] bufCount;
    logic       pop;
    logic       push;
    logic       rsrFull;
    logic [8:0] rsrData;
    logic       rsrFe;
    logic       rsrPe;
    logic       dorPending;
    logic       receiveCompleteFlag;

    assign receiveCompleteFlag = (bufCount != 2'h0);
    assign pop  = readData && receiveCompleteFlag;
    assign push = rsrFull && rxEnable && ((bufCount != SRPP_BUF_DEPTH) || pop);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdPtr    <= 1'b0;
            bufCount <= 2'h0;
        end else if (ce) begin
            if (!rxEnable) begin
                rdPtr    <= 1'b0;
                bufCount <= 2'h0;
            end else begin
                if (pop) begin
                    rdPtr <= !rdPtr;
                end
                if (push && !pop) begin
                    bufCount <= bufCount + 2'h1;
                end else if (pop && !push) begin
                    bufCount <= bufCount - 2'h1;
                end
            end
        end
    end

    logic wrPtr;
    assign wrPtr = rdPtr ^ (bufCount == 2'h1);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                bufData[i] <= 9'h000;
                bufFe[i]   <= 1'b0;
                bufPe[i]   <= 1'b0;
                bufDor[i]  <= 1'b0;
            end
        end else if (ce && push) begin
            bufData[wrPtr] <= rsrData;
            bufFe[wrPtr]   <= rsrFe;
            bufPe[wrPtr]   <= rsrPe;
            bufDor[wrPtr]  <= dorPending;
        end
    end

    // =========================================================
    // receive frame state machine
    srpp_rx_t   rxState;
    logic [3:0] rxBitCnt;
    logic [8:0] rxShift;
    logic       rxParBit;
    logic       rxCalcPar;

    assign rxCalcPar = ^(rxShift & dataMask) ^ parityOddSelect;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rxState    <= SRPP_RX_IDLE;
            rxBitCnt   <= 4'h0;
            rxShift    <= 9'h000;
            rxParBit   <= 1'b0;
            rsrFull    <= 1'b0;
            rsrData    <= 9'h000;
            rsrFe      <= 1'b0;
            rsrPe      <= 1'b0;
            dorPending <= 1'b0;
        end else if (ce) begin
            if (!rxEnable) begin
                rxState    <= SRPP_RX_IDLE;
                rsrFull    <= 1'b0;
                dorPending <= 1'b0;
            end else begin
                if (push) begin
                    rsrFull    <= 1'b0;
                    dorPending <= 1'b0;
                end
                if (sampleEn) begin
                    unique case (rxState)
                        SRPP_RX_IDLE: begin
                            if (!serialInPin) begin
                                rxState  <= SRPP_RX_DATA;
                                rxBitCnt <= 4'h0;
                                rxShift  <= 9'h000;
                                if (rsrFull && !push && (bufCount == SRPP_BUF_DEPTH)) begin
                                    dorPending <= 1'b1;
                                end
                            end
                        end
                        SRPP_RX_DATA: begin
                            rxShift[rxBitCnt] <= serialInPin;
                            rxBitCnt <= rxBitCnt + 4'h1;
                            if (rxBitCnt == nBits - 4'h1) begin
                                rxState <= parityEnableBit ? SRPP_RX_PAR : SRPP_RX_STOP;
                            end
                        end
                        SRPP_RX_PAR: begin
                            rxParBit <= serialInPin;
                            rxState  <= SRPP_RX_STOP;
                        end
                        SRPP_RX_STOP: begin
                            rxState <= SRPP_RX_IDLE;
                            if (!rsrFull || push) begin
                                rsrFull <= 1'b1;
                                rsrData <= rxShift & dataMask;
                                rsrFe   <= !serialInPin;
                                rsrPe   <= parityEnableBit && (rxCalcPar != rxParBit);
                            end
                        end
                    endcase
                end
            end
        end
    end

    // =========================================================
    // transmitter
    logic [8:0]            txBufData;
    logic                  txBufValid;
    logic [SRPP_TXF_W-1:0] txShift;
    logic [3:0]            txLeft;
    logic                  txBusy;
    logic                  txActive;
    logic                  txLoad;
    logic [SRPP_TXF_W-1:0] txFrame;
    logic [3:0]            txLen;

    assign txBusy = (txLeft != 4'h0);
    assign txLoad = txBufValid && !txBusy && txActive;

    always_comb begin
        logic [8:0] d;
        d = txBufData & dataMask;
        txFrame = {SRPP_TXF_W{1'b1}};
        txFrame[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < nBits) begin
                txFrame[i + 1] = d[i];
            end
        end
        if (parityEnableBit) begin
            txFrame[nBits + 4'h1] = ^d ^ parityOddSelect;
        end
        txLen = 4'h2 + nBits + {3'b000, parityEnableBit} + {3'b000, controlRegC[SRPP_C_STOP2]};
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txBufData  <= 9'h000;
            txBufValid <= 1'b0;
        end else if (ce) begin
            if (writeData && txEnableBit) begin
                txBufData  <= {controlRegB[SRPP_B_TXB8], pwdata[7:0]};
                txBufValid <= 1'b1;
            end else if (txLoad) begin
                txBufValid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txShift <= {SRPP_TXF_W{1'b1}};
            txLeft  <= 4'h0;
        end else if (ce) begin
            if (txLoad) begin
                txShift <= txFrame;
                txLeft  <= txLen;
            end else if (txBusy && sampleEn) begin
                txShift <= {1'b1, txShift[SRPP_TXF_W-1:1]};
                txLeft  <= txLeft - 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txActive <= 1'b0;
        end else if (ce) begin
            if (txEnableBit) begin
                txActive <= 1'b1;
            end else if (!txBufValid && !txBusy) begin
                txActive <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            serialOutPin <= 1'b1;
        end else if (ce && sampleEn) begin
            serialOutPin <= txBusy ? txShift[0] : 1'b1;
        end
    end
    assign serialOutOe = txActive;

    // =========================================================
    // pin takeover and request
    assign rxPinOverride = rxEnable;
    assign rxCompleteIrq = controlRegB[SRPP_B_RXCIE] && receiveCompleteFlag &&
                           globalIrqEnable;

    // =========================================================
    // read data
    logic [7:0] statusRegA;
    always_comb begin
        statusRegA = 8'h00;
        statusRegA[SRPP_A_RXC] = receiveCompleteFlag;
        statusRegA[SRPP_A_TXE] = !txBufValid;
        statusRegA[SRPP_A_FE]  = receiveCompleteFlag && bufFe[rdPtr];
        statusRegA[SRPP_A_DOR] = receiveCompleteFlag && bufDor[rdPtr];
        statusRegA[SRPP_A_UPE] = receiveCompleteFlag && bufPe[rdPtr] && parityEnableBit;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (apbSetup) begin
            unique case (paddr)
                SRPP_STATUS_REG_A: begin
                    prdata <= {24'h000000, statusRegA};
                end
                SRPP_CONTROL_REG_B: begin
                    prdata <= {24'h000000, controlRegB[7:2],
                               receiveCompleteFlag && bufData[rdPtr][8],
                               controlRegB[SRPP_B_TXB8]};
                end
                SRPP_CONTROL_REG_C: begin
                    prdata <= {24'h000000, controlRegC};
                end
                SRPP_DATA_BUFFER: begin
                    prdata <= {24'h000000, bufData[rdPtr][7:0]};
                end
                default: begin
                    prdata <= 32'h0000_0000;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* tb/srpp_rx_checker_asserts.sv */
/* srpp_rx_checker: port assertions for srpp_serial_rx.
   Assumes: clk_sys, rst async active high; bound below. */
`timescale 1ns/100ps
`default_nettype none
module srpp_rx_checker
    import srpp_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        bitTick,
    input wire logic        serialOutPin,
    input wire logic        serialOutOe,
    input wire logic        rxPinOverride,
    input wire logic        globalIrqEnable,
    input wire logic        rxCompleteIrq
);
    // =========================================================
    // bus phases
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_setup;
        psel && !penable && ce;
    endsequence
    sequence s_wr_ctrl_b;
        psel && penable && ce && pwrite && paddr == SRPP_CONTROL_REG_B;
    endsequence
    // =========================================================
    // checks
    irq_gate_a: assert property (rxCompleteIrq |-> globalIrqEnable)
        else $error("receive request without global enable");
    irq_rxoff_a: assert property (!rxPinOverride |-> !rxCompleteIrq)
        else $error("receive request while receiver off");
    irq_flag_a: assert property (s_setup ##0 (paddr == SRPP_STATUS_REG_A && rxCompleteIrq)
        |=> prdata[SRPP_A_RXC]) else $error("request without complete flag");
    rxen_pin_a: assert property (s_wr_ctrl_b |=> rxPinOverride == $past(pwdata[SRPP_B_RXEN]))
        else $error("pin takeover does not follow enable");
    tx_hold_a: assert property (serialOutOe && !serialOutPin |=> serialOutOe)
        else $error("transmitter released mid frame");
    tx_strobe_a: assert property ($changed(serialOutPin) |-> $past(bitTick))
        else $error("serial output moved off strobe");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
    unmapped_zero_a: assert property (s_setup ##0 (paddr[1:0] != 2'h0 || paddr > SRPP_DATA_BUFFER)
        |=> prdata == 32'h0) else $error("unmapped read not zero");
    hi_zero_a: assert property (s_setup |=> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    irq_seen_c: cover property (rxCompleteIrq);
endmodule
bind srpp_serial_rx srpp_rx_checker i_srpp_rx_checker (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .bitTick(bitTick), .serialOutPin(serialOutPin), .serialOutOe(serialOutOe),
    .rxPinOverride(rxPinOverride), .globalIrqEnable(globalIrqEnable),
    .rxCompleteIrq(rxCompleteIrq));
`default_nettype wire

/* tb/srpp_serial_node.sv */
/* srpp_serial_node: remote serial node, sends and captures frames.
   Assumes: bitTick strobe from the bench; line idles high. */
`timescale 1ns/100ps
`default_nettype none
module srpp_serial_node (
    input  wire logic clk_sys,
    input  wire logic bitTick,
    input  wire logic serialOutPin,
    output var  logic serialInPin
);
    // =========================================================
    // sender
    initial serialInPin = 1'b1;
    task automatic send(input logic [8:0] d, input int n, input logic pen,
                        input logic parBit, input logic stopBit);
        int i;
        @(posedge clk_sys iff bitTick);
        serialInPin <= 1'b0;
        for (i = 0; i < n; i++) begin
            @(posedge clk_sys iff bitTick);
            serialInPin <= d[i];
        end
        if (pen) begin
            @(posedge clk_sys iff bitTick);
            serialInPin <= parBit;
        end
        @(posedge clk_sys iff bitTick);
        serialInPin <= stopBit;
        @(posedge clk_sys iff bitTick);
        serialInPin <= 1'b1;
    endtask
    // =========================================================
    // capture
    task automatic capture(input int n, output logic [8:0] d, output logic par,
                           output logic stp, output logic ok);
        int i;
        d = 9'h000;
        ok = 1'b0;
        for (i = 0; i < 400 && !ok; i++) begin
            @(posedge clk_sys iff bitTick);
            @(negedge clk_sys);
            ok = (serialOutPin === 1'b0);
        end
        for (i = 0; i < n + 2; i++) begin
            @(posedge clk_sys iff bitTick);
            @(negedge clk_sys);
            if (i < n) d[i] = serialOutPin;
            else if (i == n) par = serialOutPin;
            else stp = serialOutPin;
        end
    endtask
endmodule
`default_nettype wire

/* tb/test_serial_receive_path_parity.sv */
/* test_serial_receive_path_parity: bench for srpp_serial_rx.
   Assumes: srpp_pkg, serial node model, bound checker. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module test_serial_receive_path_parity
    import srpp_pkg::*;
;
    logic        clk_sys, rst, ce, psel, penable, pwrite, bitTick, extClk, gie, syncSel;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdv, seed;
    logic        pready, pslverr, errv, rxd, txd, txOe, rxOvr, irq;
    logic [1:0]  tickCnt;
    int          n_checks, n_mismatch;
    srpp_serial_rx i_srpp_serial_rx (.clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bitTick(bitTick), .serialInPin(rxd),
        .externalTransferClockPin(extClk), .serialOutPin(txd), .serialOutOe(txOe),
        .rxPinOverride(rxOvr), .globalIrqEnable(gie), .rxCompleteIrq(irq));
    srpp_serial_node i_srpp_serial_node (.clk_sys(clk_sys), .bitTick(bitTick | extClk),
        .serialOutPin(txd), .serialInPin(rxd));
    // =========================================================
    // clock, strobe, helpers
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        tickCnt <= tickCnt + 2'h1;
        bitTick <= (tickCnt == 2'h3) && !syncSel;
        extClk <= (tickCnt == 2'h3) && syncSel;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic parity(input logic [8:0] d, input int n, input logic odd);
        return (^(d & 9'((16'h1 << n) - 1))) ^ odd;
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic timeout();
        n_mismatch++;
        test_done();
    endtask
    // =========================================================
    // bus master
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i <= 50; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
            if (i == 50) timeout();
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cfg(input logic pen, odd, stop2, input logic [2:0] csz, input logic txen);
        apb(1'b1, SRPP_CONTROL_REG_C, {25'h0, syncSel, pen, odd, stop2, csz[1:0], 1'b0});
        apb(1'b1, SRPP_CONTROL_REG_B, {24'h0, 3'h4, 1'b1, txen, csz[2], 2'h0});
    endtask
    task automatic wait_rxc();
        int i;
        for (i = 0; i <= 400; i++) begin
            apb(1'b0, SRPP_STATUS_REG_A, 32'h0);
            if (rdv[SRPP_A_RXC] === 1'b1) break;
            if (i == 400) timeout();
        end
    endtask
    // =========================================================
    // scenarios
    task automatic test_rx();
        int k, n;
        logic [2:0] csz;
        logic [8:0] d;
        logic [31:0] r;
        logic off;
        for (k = 0; k < 20; k++) begin
            r = rnd();
            d = 9'(rnd());
            csz = (k % 5 == 4) ? SRPP_CSZ_NINE : 3'(k % 5);
            n = (k % 5 == 4) ? 9 : 5 + k % 5;
            off = r[0] & r[2] & r[3] & k[0];
            gie <= r[7];
            cfg(r[0], r[1], r[8], csz, 1'b0);
            i_srpp_serial_node.send(d, n, r[0], parity(d, n, r[1]) ^ r[2], ~r[4]);
            wait_rxc();
            `CHK(irq, r[7]);
            if (off) cfg(1'b0, r[1], 1'b0, csz, 1'b0);
            apb(1'b1, SRPP_STATUS_REG_A, 32'h0);
            apb(1'b0, SRPP_STATUS_REG_A, 32'h0);
            `CHK(rdv[SRPP_A_FE], r[4]);
            `CHK(rdv[SRPP_A_UPE], r[0] & r[2] & ~off);
            `CHK(rdv[SRPP_A_DOR], 1'b0);
            apb(1'b0, SRPP_CONTROL_REG_B, 32'h0);
            if (n == 9) `CHK(rdv[SRPP_B_RXB8], d[8]);
            apb(1'b0, SRPP_DATA_BUFFER, 32'h0);
            `CHK(rdv, 32'(d[7:0] & 8'((16'h1 << n) - 1)));
            apb(1'b0, SRPP_STATUS_REG_A, 32'h0);
            `CHK(rdv[SRPP_A_RXC], 1'b0);
            `CHK(irq, 1'b0);
        end
        $display("test rx done");
    endtask
    task automatic test_ovr();
        logic [7:0] d [5];
        logic dor;
        int k;
        {dor, syncSel} = 2'h1;
        cfg(1'b0, 1'b0, 1'b0, 3'h3, 1'b0);
        for (k = 0; k < 5; k++) d[k] = 8'(rnd());
        for (k = 0; k < 4; k++) i_srpp_serial_node.send({1'b0, d[k]}, 8, 1'b0, 1'b0, 1'b1);
        for (k = 0; k < 3; k++) begin
            apb(1'b0, SRPP_STATUS_REG_A, 32'h0);
            dor = dor | rdv[SRPP_A_DOR];
            apb(1'b0, SRPP_DATA_BUFFER, 32'h0);
            `CHK(rdv[7:0], d[k]);
        end
        `CHK(dor, 1'b1);
        apb(1'b0, SRPP_STATUS_REG_A, 32'h0);
        `CHK(rdv[SRPP_A_RXC], 1'b0);
        i_srpp_serial_node.send({1'b0, d[4]}, 8, 1'b0, 1'b0, 1'b1);
        wait_rxc();
        `CHK(rdv[SRPP_A_DOR], 1'b0);
        apb(1'b1, SRPP_CONTROL_REG_B, 32'h0);
        apb(1'b0, SRPP_STATUS_REG_A, 32'h0);
        `CHK(rdv[SRPP_A_RXC], 1'b0);
        `CHK(rxOvr, 1'b0);
        $display("test ovr done");
    endtask
    task automatic test_tx();
        logic [8:0] got;
        logic par, stp, ok;
        logic [7:0] d;
        int k, i;
        syncSel = 1'b0;
        for (k = 0; k < 4; k++) begin
            d = 8'(rnd());
            cfg(1'b1, k[0], 1'b0, 3'h3, 1'b1);
            fork
                i_srpp_serial_node.capture(8, got, par, stp, ok);
                begin
                    apb(1'b1, SRPP_DATA_BUFFER, 32'(d));
                    apb(1'b1, SRPP_CONTROL_REG_B, 32'h10);
                    @(negedge clk_sys);
                    `CHK(txOe, 1'b1);
                end
            join
            `CHK({ok, stp, got[7:0]}, {2'h3, d});
            `CHK(par, parity({1'b0, d}, 8, k[0]));
            for (i = 0; i <= 100 && txOe !== 1'b0; i++) @(negedge clk_sys);
            `CHK(txOe, 1'b0);
        end
        $display("test tx done");
    endtask
    // =========================================================
    // main sequence and watchdog
    initial begin
        {ce, extClk} = 2'h2;
        {psel, penable, pwrite, bitTick, gie, syncSel} = 6'h00;
        {paddr, pwdata, tickCnt} = 42'h0;
        {n_checks, n_mismatch} = 64'h0;
        seed = 32'h00014c1b;
        rst = 1'b1;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        apb(1'b0, SRPP_CONTROL_REG_B, 32'h0);
        `CHK(rdv, 32'(SRPP_B_RESET));
        apb(1'b0, SRPP_CONTROL_REG_C, 32'h0);
        `CHK(rdv, 32'(SRPP_C_RESET));
        apb(1'b0, SRPP_STATUS_REG_A, 32'h0);
        `CHK(rdv & 32'h9c, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        `CHK({errv, rdv}, 33'h100000000);
        $display("test reset done");
        test_rx();
        test_ovr();
        test_tx();
        test_done();
    end
    initial begin
        repeat (100000) @(posedge clk_sys);
        timeout();
    end
endmodule
`default_nettype wire
